/* rtl/adc_read_port.v */
`timescale 1ns/100ps
`include "adc_read_port_map.vh"

// =====================================================
// Sample FIFO
// =====================================================
module sample_fifo #(
    parameter WIDTH = `RESULT_W,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW = 3
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] in_data_i,
    input wire in_valid_i,
    output wire in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire out_valid_o,
    input wire out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    reg ready_q;
    wire [AW:0] cnt_d;
    wire do_wr;
    wire do_rd;

    // Ready is registered so the top-level port comes straight from a flip-flop
    assign in_ready_o = ready_q;
    assign cnt_d = (do_wr & ~do_rd) ? cnt_q + 1'b1 :
                   (do_rd & ~do_wr) ? cnt_q - 1'b1 : cnt_q;
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_q];
    assign do_wr = in_valid_i & in_ready_o;
    assign do_rd = out_valid_o & out_ready_i;

    always @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_q] <= in_data_i;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            ready_q <= 1'b1;
        end else begin
            if (do_wr) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (do_rd) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            cnt_q <= cnt_d;
            ready_q <= (cnt_d != DEPTH[AW:0]);
        end
    end
endmodule // sample_fifo

// =====================================================
// Conversion control and read port
// =====================================================
module adc_read_port #(
    parameter CONV_CYCLES = `CONV_CYCLES,
    parameter CYCLE_CYCLES = `CYCLE_CYCLES
) (
    input wire SYS_CLK_I,
    input wire SYS_RST_I,
    input wire START_CONVERSION_N_I,
    input wire CHIP_SELECT_N_I,
    input wire OUTPUT_ENABLE_N_I,
    input wire DONE_FLAG_ENABLE_N_I,
    input wire OFFSET_STRAP_I,
    input wire [`RESULT_W-1:0] SAMPLE_I,
    input wire SAMPLE_VALID_I,
    output wire SAMPLE_READY_O,
    output reg [`RESULT_W-1:0] RESULT_BUS_O,
    output reg RESULT_BUS_OE_O,
    output reg DONE_FLAG_O,
    output reg DONE_FLAG_OE_O
);
    localparam ST_IDLE = 2'b01;
    localparam ST_CONV = 2'b10;

    // Two-stage synchronisers for the five control pins; SAMPLE_I and SAMPLE_VALID_I are not synchronised
    reg [4:0] meta_q;
    reg [4:0] sync_q;
    reg sc_prev_q;
    reg oe_prev_q;
    reg [1:0] state_q;
    reg [`CNT_W-1:0] cnt_q;
    reg [`RESULT_W-1:0] result_q;
    reg strap_q;
    reg driving_q;
    wire sc_n;
    wire cs_n;
    wire oe_n;
    wire en_n;
    wire start_fall;
    wire oe_fall;
    wire [`RESULT_W-1:0] coded;
    wire [`RESULT_W-1:0] fifo_data;
    wire fifo_valid;
    wire take;

    assign sc_n = sync_q[0];
    assign cs_n = sync_q[1];
    assign oe_n = sync_q[2];
    assign en_n = sync_q[3];
    assign start_fall = sc_prev_q & ~sc_n;
    assign oe_fall = oe_prev_q & ~oe_n;
    // Sample taken when the conversion time runs out
    assign take = (state_q == ST_CONV) && (cnt_q == CONV_CYCLES[`CNT_W-1:0] - 1'b1);

    // Straight binary from the sampler; flip MSB for twos complement
    assign coded = {fifo_data[`MSB_POS] ^ strap_q, fifo_data[`MSB_POS-1:0]};

    sample_fifo #(
        .WIDTH(`RESULT_W),
        .DEPTH(`FIFO_DEPTH),
        .AW(3)
    ) u_fifo (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .in_data_i(SAMPLE_I),
        .in_valid_i(SAMPLE_VALID_I),
        .in_ready_o(SAMPLE_READY_O),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(take)
    );

    always @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            meta_q <= 5'h1F;
            sync_q <= 5'h1F;
            sc_prev_q <= 1'b1;
            oe_prev_q <= 1'b1;
            state_q <= ST_IDLE;
            cnt_q <= {`CNT_W{1'b0}};
            result_q <= {`RESULT_W{1'b0}};
            strap_q <= 1'b0;
            driving_q <= 1'b0;
            RESULT_BUS_O <= {`RESULT_W{1'b0}};
            RESULT_BUS_OE_O <= 1'b0;
            DONE_FLAG_O <= 1'b1;
            DONE_FLAG_OE_O <= 1'b0;
        end else begin
            meta_q <= {OFFSET_STRAP_I, DONE_FLAG_ENABLE_N_I, OUTPUT_ENABLE_N_I,
                       CHIP_SELECT_N_I, START_CONVERSION_N_I};
            sync_q <= meta_q;
            sc_prev_q <= sc_n;
            oe_prev_q <= oe_n;
            strap_q <= sync_q[4];
            // A conversion in progress is not restarted; a new start is taken as soon as the state is idle again
            case (state_q)
                ST_IDLE: begin
                    if (start_fall) begin
                        state_q <= ST_CONV;
                        cnt_q <= {`CNT_W{1'b0}};
                        DONE_FLAG_O <= 1'b0;
                    end
                end
                ST_CONV: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (take) begin
                        state_q <= ST_IDLE;
                        DONE_FLAG_O <= 1'b1;
                        if (fifo_valid) begin
                            result_q <= coded;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    DONE_FLAG_O <= 1'b1;
                end
            endcase
            DONE_FLAG_OE_O <= ~en_n;
            // Drive begins on the falling edge of output enable, while chip select is low
            if (oe_n | cs_n) begin
                driving_q <= 1'b0;
                RESULT_BUS_OE_O <= 1'b0;
            end else if (oe_fall) begin
                driving_q <= 1'b1;
                RESULT_BUS_OE_O <= 1'b1;
            end
            RESULT_BUS_O <= result_q;
        end
    end
endmodule // adc_read_port

/* rtl/adc_read_port_map.vh */
// What this block does
// - Conversion done 6.36 us after start falls, 6.3 us after the start is seen
// - Full conversion cycle of 7.8 us is not enforced; a start is taken as soon as idle
// - Done flag low while converting, high after
// - Done flag driven only while enable low
// - Whole 14-bit result presented at once
// - Result driven after output enable falls while chip select is low
// - Result bus and done flag three-state when not enabled
// - Strap selects straight binary or twos complement
// - Start input is active low
// - Start ignores chip select level
`ifndef ADC_READ_PORT_MAP_VH
`define ADC_READ_PORT_MAP_VH

// =====================================================
// Timing
// =====================================================
`define CLK_PERIOD_NS 20
`define CONV_TIME_NS 6300
`define CONV_CYCLES ((`CONV_TIME_NS) / (`CLK_PERIOD_NS))
`define CYCLE_TIME_NS 7800
`define CYCLE_CYCLES ((`CYCLE_TIME_NS) / (`CLK_PERIOD_NS))
`define CNT_W 9

// =====================================================
// Data
// =====================================================
`define RESULT_W 14
`define MSB_POS 13
`define FIFO_DEPTH 8

`endif

/* tb/sample_source.sv */
`timescale 1ns/100ps
// =====================================
// Sampler stand-in, stalls while en_i is low
module sample_source (
    input wire logic clk_i,
    input wire logic en_i,
    input wire logic ready_i,
    output logic [13:0] data_o,
    output logic valid_o
);
    logic [13:0] data_q = 14'h0100;
    // Idle data is inverted so a stale word is never mistaken for a fresh one
    assign data_o = en_i ? data_q : ~data_q;
    assign valid_o = en_i;
    always @(posedge clk_i) if (en_i && ready_i) data_q <= data_q + 14'h0001;
endmodule // sample_source

/* tb/adc_read_port_monitor.sv */
`timescale 1ns/100ps
// =====================================
// Port checker
module adc_read_port_monitor #(
    parameter int CONV_CYCLES = 315
) (
    input wire SYS_CLK_I,
    input wire SYS_RST_I,
    input wire START_CONVERSION_N_I,
    input wire CHIP_SELECT_N_I,
    input wire OUTPUT_ENABLE_N_I,
    input wire DONE_FLAG_ENABLE_N_I,
    input wire [13:0] RESULT_BUS_O,
    input wire RESULT_BUS_OE_O,
    input wire DONE_FLAG_O,
    input wire DONE_FLAG_OE_O
);
    localparam int CMAX = CONV_CYCLES + 3;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    sequence s_low;
        !DONE_FLAG_O [*4];
    endsequence
    AST_START: assert property ($fell(START_CONVERSION_N_I) && DONE_FLAG_O |-> ##[2:6] !DONE_FLAG_O)
        else $error("start ignored");
    AST_CAUSE: assert property ($fell(DONE_FLAG_O) |-> !$past(START_CONVERSION_N_I, 2))
        else $error("flag fell without start");
    AST_CONV: assert property ($fell(DONE_FLAG_O) |-> s_low ##[1:CMAX] DONE_FLAG_O)
        else $error("conversion length wrong");
    AST_FLAG_ON: assert property ($fell(DONE_FLAG_ENABLE_N_I) |-> ##[1:5] DONE_FLAG_OE_O)
        else $error("flag not driven");
    AST_FLAG_OFF: assert property ($rose(DONE_FLAG_ENABLE_N_I) |-> ##[1:5] !DONE_FLAG_OE_O)
        else $error("flag not floated");
    AST_BUS_ON: assert property ($fell(OUTPUT_ENABLE_N_I) && !CHIP_SELECT_N_I |-> ##[1:6] RESULT_BUS_OE_O)
        else $error("bus not driven");
    AST_BUS_OFF: assert property ($rose(OUTPUT_ENABLE_N_I) |-> ##[1:5] !RESULT_BUS_OE_O)
        else $error("bus not floated");
    AST_HOLD: assert property ($changed(RESULT_BUS_O) |-> DONE_FLAG_O)
        else $error("result changed mid conversion");
endmodule // adc_read_port_monitor

bind adc_read_port adc_read_port_monitor #(.CONV_CYCLES(CONV_CYCLES)) mon (
    .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .START_CONVERSION_N_I(START_CONVERSION_N_I),
    .CHIP_SELECT_N_I(CHIP_SELECT_N_I), .OUTPUT_ENABLE_N_I(OUTPUT_ENABLE_N_I),
    .DONE_FLAG_ENABLE_N_I(DONE_FLAG_ENABLE_N_I), .RESULT_BUS_O(RESULT_BUS_O),
    .RESULT_BUS_OE_O(RESULT_BUS_OE_O), .DONE_FLAG_O(DONE_FLAG_O), .DONE_FLAG_OE_O(DONE_FLAG_OE_O));

/* tb/tb_adc_read_port.sv */
`timescale 1ns/100ps
// =====================================
// Bench
module tb_adc_read_port;
    logic clk, rst, sc_n, cs_n, oe_n, fen_n, strap, en;
    logic [13:0] exp;
    wire [13:0] sample, bus;
    wire valid, ready, bus_oe, flag, flag_oe;
    int err_total, compares, k, n;
    sample_source src (.clk_i(clk), .en_i(en), .ready_i(ready), .data_o(sample), .valid_o(valid));
    adc_read_port #(.CONV_CYCLES(8)) dut (.SYS_CLK_I(clk), .SYS_RST_I(rst),
        .START_CONVERSION_N_I(sc_n), .CHIP_SELECT_N_I(cs_n), .OUTPUT_ENABLE_N_I(oe_n),
        .DONE_FLAG_ENABLE_N_I(fen_n), .OFFSET_STRAP_I(strap), .SAMPLE_I(sample),
        .SAMPLE_VALID_I(valid), .SAMPLE_READY_O(ready), .RESULT_BUS_O(bus),
        .RESULT_BUS_OE_O(bus_oe), .DONE_FLAG_O(flag), .DONE_FLAG_OE_O(flag_oe));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task chk(input logic [13:0] got, input logic [13:0] want);
        compares++;
        if (got !== want) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task test_done;
        $display("compares=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task convert;
        @(posedge clk) sc_n <= 1'b0;
        repeat (6) @(posedge clk);
        sc_n <= 1'b1;
        #1 chk(flag, 14'h0000);
        // Look just after each edge so the flag's update on that edge is seen
        for (n = 0; n < 40 && flag !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 40) begin
            err_total++;
            test_done;
        end
        repeat (3) @(posedge clk);
    endtask
    task read(input logic [13:0] want);
        @(posedge clk) cs_n <= 1'b0;
        @(posedge clk) oe_n <= 1'b0;
        repeat (7) @(posedge clk);
        #1 chk(bus_oe, 14'h0001);
        chk(bus, want);
        @(posedge clk) oe_n <= 1'b1;
        cs_n <= 1'b1;
        repeat (21) @(posedge clk);
        #1 chk(bus_oe, 14'h0000);
    endtask
    initial begin
        {rst, sc_n, cs_n, oe_n} = 4'hF;
        {fen_n, strap, en} = 3'h0;
        {err_total, compares} = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk) en <= 1'b1;
        repeat (20) @(posedge clk);
        // Eight words queued and the source still pushing, so the buffer must refuse
        #1 chk(ready, 14'h0000);
        @(posedge clk) en <= 1'b0;
        // Conversion 8 finds the buffer empty and must keep the old word
        for (k = 0; k < 10; k++) begin
            @(posedge clk) strap <= (k == 8) ? 1'b1 : k[0];
            if (k == 9) en <= 1'b1;
            convert;
            exp = (14'h0100 + 14'((k < 8) ? k : k - 1)) ^ {strap, 13'h0000};
            read(exp);
            read(exp);
            $display("conversion %0d done", k);
        end
        @(posedge clk) fen_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk(flag_oe, 14'h0000);
        @(posedge clk) fen_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk(flag_oe, 14'h0001);
        test_done;
    end
endmodule // tb_adc_read_port
